// *** core/mgmt_timing.sv ***
// management control and status timing of the pluggable module
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
module mgmt_timing
    import mgmt_timing_pkg::*;
#(
    parameter int INIT_COUNT  = INIT_CYCLES,
    parameter int PULSE_COUNT = RESET_PULSE_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        reset_pin_n,
    input  wire logic        module_select_n,
    input  wire logic        low_power_pin,
    input  wire logic        interrupt_pin_n_in,
    output logic             interrupt_pin_n_out,
    output logic             interrupt_pin_n_oe,
    input  wire events_t     events,
    output logic             bus_respond,
    output logic             low_power_active,
    output logic             data_not_ready
);
    pins_t pins_raw;
    pins_t pins;

    assign pins_raw = '{int_level: interrupt_pin_n_in, low_power: low_power_pin,
                        select_n: module_select_n, reset_n: reset_pin_n};

    // reset pin and select idle high, low power idles low
    pin_sync #(
        .W   (4),
        .RST (4'hb)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .d       (pins_raw),
        .q       (pins)
    );

    // state machine and init timer
    mgmt_state_t state;
    mgmt_state_t next_state;
    logic [31:0] init_count;
    logic [31:0] next_init_count;
    logic [31:0] low_count;
    logic [31:0] next_low_count;
    logic        ready_event;

    always_comb begin
        next_state      = state;
        next_init_count = init_count;
        next_low_count  = pins.reset_n ? 32'h0 : low_count + 32'h1;
        ready_event     = 1'b0;
        if (!pins.reset_n && low_count >= 32'(PULSE_COUNT - 1)) begin
            next_low_count = low_count;
        end
        case (state)
            ST_HOLD: begin
                next_init_count = 32'h0;
                if (pins.reset_n) begin
                    next_state = ST_INIT;
                end
            end
            ST_INIT: begin
                next_init_count = init_count + 32'h1;
                if (init_count >= 32'(INIT_COUNT - 1)) begin
                    next_state  = ST_READY;
                    ready_event = 1'b1;
                end
            end
            ST_READY: begin
                next_init_count = 32'h0;
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
        // a pulse longer than the minimum always holds the block
        if (!pins.reset_n && low_count >= 32'(PULSE_COUNT - 1)) begin
            next_state      = ST_HOLD;
            next_init_count = 32'h0;
            ready_event     = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state      <= ST_INIT;
            init_count <= 32'h0;
            low_count  <= 32'h0;
        end else begin
            state      <= next_state;
            init_count <= next_init_count;
            low_count  <= next_low_count;
        end
    end

    // register bus: one wait cycle, then answer
    logic                ack;
    logic                next_ack;
    logic [31:0]         next_readdata;
    logic [FLAG_W-1:0]   flags;
    logic [FLAG_W-1:0]   next_flags;
    logic [FLAG_W-1:0]   mask;
    logic [FLAG_W-1:0]   next_mask;
    logic                pdown;
    logic                next_pdown;
    logic [FLAG_W-1:0]   events_prev;
    logic [FLAG_W-1:0]   rise;
    logic                flags_read;
    logic                taken_write;

    function automatic logic [31:0] status_word(input logic nr, input logic lp,
                                                input logic rsp, input logic pin);
        logic [31:0] w;
        w = 32'h0;
        w[STATUS_NOT_READY_BIT] = nr;
        w[STATUS_LOW_POWER_BIT] = lp;
        w[STATUS_RESPOND_BIT]   = rsp;
        w[STATUS_INT_PIN_BIT]   = pin;
        return w;
    endfunction

    assign waitrequest = (read || write) && !ack;
    assign flags_read  = ack && read && address == ADDR_FLAGS;
    assign taken_write = ack && write;
    assign rise        = {1'b0, events} & ~events_prev;

    always_comb begin
        next_ack      = (read || write) && !ack;
        next_readdata = readdata;
        if ((read || write) && !ack) begin
            next_readdata = 32'h0;
        end
        if (read && !ack) begin
            case (address)
                ADDR_STATUS:  next_readdata = status_word(data_not_ready, low_power_active,
                                                          bus_respond, pins.int_level);
                ADDR_FLAGS:   next_readdata = {15'h0, flags};
                ADDR_MASK:    next_readdata = {15'h0, mask};
                ADDR_CONTROL: next_readdata = {31'h0, pdown};
                default:      next_readdata = 32'h0;
            endcase
        end
    end

    // clearing happens at the taking edge, before any bus reference edge
    always_comb begin
        next_flags = flags;
        next_mask  = mask;
        next_pdown = pdown;
        // only bits the host was shown are cleared, so a flag set in the wait cycle is kept
        if (flags_read) begin
            next_flags = flags & ~readdata[FLAG_W-1:0];
        end
        // a new event in the clearing cycle survives
        next_flags = next_flags | rise;
        if (ready_event) begin
            next_flags[FLAG_READY_BIT] = 1'b1;
        end
        if (taken_write && address == ADDR_MASK) begin
            next_mask = writedata[FLAG_W-1:0];
        end
        if (taken_write && address == ADDR_CONTROL) begin
            next_pdown = writedata[CONTROL_PDOWN_BIT];
        end
        if (state == ST_HOLD) begin
            next_flags = FLAGS_RESET;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack         <= 1'b0;
            readdata    <= 32'h0;
            flags       <= FLAGS_RESET;
            mask        <= MASK_RESET;
            pdown       <= CONTROL_RESET;
            events_prev <= '0;
        end else begin
            ack         <= next_ack;
            readdata    <= next_readdata;
            flags       <= next_flags;
            mask        <= next_mask;
            pdown       <= next_pdown;
            events_prev <= {1'b0, events};
        end
    end

    // pin side outputs, all from flops
    logic irq;
    logic next_irq;
    logic next_respond;
    logic next_low_power;
    logic next_not_ready;

    always_comb begin
        next_irq       = |(flags & ~mask);
        next_respond   = state == ST_READY && !pins.select_n;
        next_low_power = pins.low_power || pdown;
        next_not_ready = state != ST_READY;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq              <= 1'b0;
            bus_respond      <= 1'b0;
            low_power_active <= 1'b0;
            data_not_ready   <= 1'b1;
        end else begin
            irq              <= next_irq;
            bus_respond      <= next_respond;
            low_power_active <= next_low_power;
            data_not_ready   <= next_not_ready;
        end
    end

    // open drain: only ever pulls low
    assign interrupt_pin_n_out = 1'b0;
    assign interrupt_pin_n_oe  = irq;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_flags_read;
        flags_read && rise == '0 && !ready_event && flags == readdata[FLAG_W-1:0];
    endsequence

    sequence s_all_quiet;
        (mask == {FLAG_W{1'b1}}) [*2];
    endsequence

    property p_init_holds_not_ready;
        state == ST_INIT |-> ##1 data_not_ready;
    endproperty
    a_init_holds_not_ready: assert property (p_init_holds_not_ready)
        else $error("data not ready dropped during init");

    property p_ready_raises_flag;
        state == ST_INIT && next_state == ST_READY |-> ##1 flags[FLAG_READY_BIT] ##1 !data_not_ready;
    endproperty
    a_ready_raises_flag: assert property (p_ready_raises_flag)
        else $error("ready flag not set at end of init");

    property p_init_bound;
        state == ST_INIT |-> init_count < 32'(INIT_COUNT);
    endproperty
    a_init_bound: assert property (p_init_bound)
        else $error("init ran past its limit");

    property p_pulse_holds;
        !pins.reset_n && low_count == 32'(PULSE_COUNT - 1) |-> ##1 state == ST_HOLD;
    endproperty
    a_pulse_holds: assert property (p_pulse_holds)
        else $error("long reset pulse not taken");

    property p_release_restarts;
        state == ST_HOLD && pins.reset_n |-> ##1 state == ST_INIT ##1 data_not_ready;
    endproperty
    a_release_restarts: assert property (p_release_restarts)
        else $error("init did not restart after reset pin");

    property p_event_to_pin;
        state == ST_READY && rise != '0 && (rise & ~mask) != '0 && !flags_read
            |-> ##1 (flags & $past(rise)) == $past(rise) ##[1:2] interrupt_pin_n_oe;
    endproperty
    a_event_to_pin: assert property (p_event_to_pin)
        else $error("event did not reach interrupt pin");

    property p_los_flag;
        state != ST_HOLD && $rose(events.los[0]) |-> ##1 flags[0];
    endproperty
    a_los_flag: assert property (p_los_flag)
        else $error("loss flag not set");

    property p_fault_flag;
        state != ST_HOLD && $rose(events.fault[0]) |-> ##1 flags[4];
    endproperty
    a_fault_flag: assert property (p_fault_flag)
        else $error("fault flag not set");

    property p_other_flag;
        state != ST_HOLD && $rose(events.other[0]) |-> ##1 flags[8];
    endproperty
    a_other_flag: assert property (p_other_flag)
        else $error("other flag not set");

    property p_read_releases;
        s_flags_read |-> ##1 flags == '0 ##1 !interrupt_pin_n_oe;
    endproperty
    a_read_releases: assert property (p_read_releases)
        else $error("interrupt held after clearing read");

    property p_mask_inhibits;
        s_all_quiet |-> ##1 !interrupt_pin_n_oe;
    endproperty
    a_mask_inhibits: assert property (p_mask_inhibits)
        else $error("masked source drove interrupt");

    property p_deselect;
        pins.select_n |-> ##1 !bus_respond;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("still responding after deselect");

    property p_select;
        state == ST_READY && !pins.select_n |-> ##1 bus_respond;
    endproperty
    a_select: assert property (p_select)
        else $error("not responding after select");

    property p_power_down;
        taken_write && address == ADDR_CONTROL && writedata[CONTROL_PDOWN_BIT]
            |-> ##2 low_power_active;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power down bit not honoured");

    property p_low_power_pin;
        pins.low_power |-> ##1 low_power_active;
    endproperty
    a_low_power_pin: assert property (p_low_power_pin)
        else $error("low power pin not honoured");

    property p_unmask_resume;
        taken_write && address == ADDR_MASK && state != ST_HOLD && next_state != ST_HOLD
            && (flags & ~writedata[FLAG_W-1:0]) != '0 |-> ##2 interrupt_pin_n_oe;
    endproperty
    a_unmask_resume: assert property (p_unmask_resume)
        else $error("unmasked flag did not reach interrupt pin");

    property p_pdown_release;
        taken_write && address == ADDR_CONTROL && !writedata[CONTROL_PDOWN_BIT]
            ##1 !pins.low_power |-> ##1 !low_power_active;
    endproperty
    a_pdown_release: assert property (p_pdown_release)
        else $error("power down clear not honoured");

endmodule

// *** core/mgmt_timing_pkg.sv ***
// package of constants and types for the module management timing block
//
// Notes on behaviour
// - after power-up the block is fully functional within 2000 ms
// - a reset pin low longer than 2 us is always taken as a reset
// - the serial bus is answered within 2000 ms of power-up
// - within 2000 ms data-not-ready clears and the interrupt pin asserts
// - after the reset pin rises, fully functional within 2000 ms
// - fully functional means interrupt asserted because data-not-ready cleared
// - low-power pin high gives the lower power level within 100 us
// - interrupt pin driven low within 200 ms of any triggering condition
// - flags clear on read; interrupt pin released within 500 us after
// - receive loss sets its flag and asserts interrupt within 100 ms
// - transmit fault sets its flag and asserts interrupt within 200 ms
// - any other condition sets its flag and asserts interrupt within 200 ms
// - a mask bit set stops its source asserting interrupt within 100 ms
// - a mask bit cleared resumes that source within 100 ms
// - bus answered within 100 us of select low; host waits that long
// - bus no longer answered within 100 us of select released
// - power-down bit set gives the lower power level within 100 ms
// - power-down bit cleared gives full function within 300 ms
// - clearing-read timing starts at first falling bus clock after stop
// - mask or power-down write timing starts at first falling clock after stop
package mgmt_timing_pkg;

    localparam int CLK_KHZ            = 100000;
    localparam int INIT_TIME_MS       = 2000;
    localparam int INIT_CYCLES        = INIT_TIME_MS * CLK_KHZ;
    localparam int RESET_PULSE_US     = 2;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_US * CLK_KHZ + 999) / 1000;
    localparam int SELECT_TIME_US     = 100;
    localparam int SELECT_CYCLES      = SELECT_TIME_US * CLK_KHZ / 1000;
    localparam int INT_RELEASE_US     = 500;
    localparam int INT_RELEASE_CYCLES = INT_RELEASE_US * CLK_KHZ / 1000;

    localparam logic [3:0]  ADDR_STATUS  = 4'h0;
    localparam logic [3:0]  ADDR_FLAGS   = 4'h1;
    localparam logic [3:0]  ADDR_MASK    = 4'h2;
    localparam logic [3:0]  ADDR_CONTROL = 4'h3;

    localparam int STATUS_NOT_READY_BIT = 0;
    localparam int STATUS_LOW_POWER_BIT = 1;
    localparam int STATUS_RESPOND_BIT   = 2;
    localparam int STATUS_INT_PIN_BIT   = 3;
    localparam int CONTROL_PDOWN_BIT    = 0;

    localparam int FLAG_W         = 17;
    localparam int FLAG_READY_BIT = 16;
    localparam logic [FLAG_W-1:0] MASK_RESET    = 17'h00000;
    localparam logic [FLAG_W-1:0] FLAGS_RESET   = 17'h00000;
    localparam logic              CONTROL_RESET = 1'b0;

    // flag sources, packed in the same order as the flag register
    typedef struct packed {
        logic [7:0] other;
        logic [3:0] fault;
        logic [3:0] los;
    } events_t;

    // pins from outside the clock domain, synchronised together
    typedef struct packed {
        logic int_level;
        logic low_power;
        logic select_n;
        logic reset_n;
    } pins_t;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_INIT,
        ST_READY
    } mgmt_state_t;

endpackage

// *** core/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
module pin_sync
    import mgmt_timing_pkg::*;
#(
    parameter int          W   = 4,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // s1 feeds only s2; the filter looks at s2 and s3
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
            q  <= RST;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule

// *** test/host_board.sv ***
// host board model: reset, select and low-power pins plus the pulled-up interrupt wire
module host_board (
    input  wire logic mclk,
    input  wire logic int_oe,
    input  wire logic int_out,
    output logic      int_wire,
    output logic      reset_pin_n,
    output logic      module_select_n,
    output logic      low_power_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // open drain with pull-up: a released wire reads high
    assign int_wire = int_oe ? int_out : 1'b1;

    initial begin
        reset_pin_n     = 1'b1;
        module_select_n = 1'b1;
        low_power_pin   = 1'b0;
    end

    // held low well past the minimum pulse width
    task automatic pulse_reset(input int cyc);
        @(posedge mclk);
        reset_pin_n <= 1'b0;
        repeat (cyc) @(posedge mclk);
        reset_pin_n <= 1'b1;
    endtask

    // caller waits for bus_respond before addressing the module
    task automatic set_select(input logic v);
        @(posedge mclk);
        module_select_n <= v;
    endtask

    task automatic set_lp(input logic v);
        @(posedge mclk);
        low_power_pin <= v;
    endtask
endmodule

// *** test/mgmt_timing_test.sv ***
// self-checking bench for the management timing block
module mgmt_timing_test import mgmt_timing_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // short counts keep the run brief
    localparam int INIT_N  = 50;
    localparam int PULSE_N = 8;
    localparam int S_NR    = 0;
    localparam int S_OE    = 1;
    localparam int S_RSP   = 2;
    localparam int S_LP    = 3;

    logic        mclk;
    logic        reset_n;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        rst_pin_n;
    logic        sel_n;
    logic        lp_pin;
    logic        int_wire;
    logic        interrupt_pin_n_out;
    logic        interrupt_pin_n_oe;
    events_t     events;
    logic        bus_respond;
    logic        low_power_active;
    logic        data_not_ready;
    logic [31:0] rd;
    int          err_total;
    int          n_tests;
    int          idx;
    int          corner [6] = '{0, 3, 4, 7, 8, 15};

    mgmt_timing #(.INIT_COUNT(INIT_N), .PULSE_COUNT(PULSE_N)) mgmt_timing_i (
        .mclk                (mclk),
        .reset_n             (reset_n),
        .address             (address),
        .read                (read),
        .write               (write),
        .writedata           (writedata),
        .readdata            (readdata),
        .waitrequest         (waitrequest),
        .reset_pin_n         (rst_pin_n),
        .module_select_n     (sel_n),
        .low_power_pin       (lp_pin),
        .interrupt_pin_n_in  (int_wire),
        .interrupt_pin_n_out (interrupt_pin_n_out),
        .interrupt_pin_n_oe  (interrupt_pin_n_oe),
        .events              (events),
        .bus_respond         (bus_respond),
        .low_power_active    (low_power_active),
        .data_not_ready      (data_not_ready)
    );

    host_board host_board_i (
        .mclk            (mclk),
        .int_oe          (interrupt_pin_n_oe),
        .int_out         (interrupt_pin_n_out),
        .int_wire        (int_wire),
        .reset_pin_n     (rst_pin_n),
        .module_select_n (sel_n),
        .low_power_pin   (lp_pin)
    );

    always #5 mclk = ~mclk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            S_NR:    return data_not_ready;
            S_OE:    return interrupt_pin_n_oe;
            S_RSP:   return bus_respond;
            default: return low_power_active;
        endcase
    endfunction

    function automatic logic [31:0] flag_bit(input int i);
        return 32'h1 << i;
    endfunction

    function automatic logic [31:0] status(input logic nr, input logic lp, input logic rsp, input logic lvl);
        return {28'h0, lvl, rsp, lp, nr};
    endfunction

    // bounded wait for a level, sampled away from the clock edge
    task automatic wait_lvl(input string nm, input int s, input logic want, input int lim);
        int n;
        n = 0;
        while (pick(s) !== want && n < lim) begin
            @(negedge mclk);
            n++;
        end
        check(nm, {31'h0, pick(s)}, {31'h0, want});
    endtask

    // one avalon transfer; request held until waitrequest is sampled low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        address   <= a;
        writedata <= d;
        read      <= !wr;
        write     <= wr;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        // one wait cycle plus the taking cycle
        check("bus_answer", n, 2);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
        bus_xfer(1'b0, a, 32'h0, rd);
        check(nm, rd, exp);
    endtask

    task automatic fire(input int i);
        @(posedge mclk);
        events <= events_t'(16'h1 << i);
        @(posedge mclk);
        events <= '0;
    endtask

    task automatic test_done(input string nm);
        $display("test %s done: %0d checks, %0d mismatches", nm, n_tests, err_total);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // run needs about 400 cycles; a hang is cut at ten thousand
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end

    initial begin
        mclk      = 1'b0;
        reset_n   = 1'b0;
        address   = 4'h0;
        read      = 1'b0;
        write     = 1'b0;
        writedata = 32'h0;
        events    = '0;
        err_total = 0;
        n_tests   = 0;
        void'($urandom(38));
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;

        wait_lvl("not_ready_fall", S_NR, 1'b0, INIT_N + 20);
        wait_lvl("ready_int", S_OE, 1'b1, 4);
        check("int_drive_low", {31'h0, interrupt_pin_n_out}, 32'h0);
        repeat (6) @(posedge mclk);
        rd_chk("status_ready", ADDR_STATUS, status(1'b0, 1'b0, 1'b0, 1'b0));
        rd_chk("ready_flag", ADDR_FLAGS, flag_bit(FLAG_READY_BIT));
        wait_lvl("ready_release", S_OE, 1'b0, 10);
        rd_chk("flags_cleared", ADDR_FLAGS, 32'h0);
        rd_chk("unmapped", 4'h9, 32'h0);
        bus_xfer(1'b1, ADDR_STATUS, 32'hffffffff, rd);
        rd_chk("status_ro", ADDR_STATUS, status(1'b0, 1'b0, 1'b0, 1'b1));
        test_done("power_up");

        host_board_i.set_select(1'b0);
        wait_lvl("select_on", S_RSP, 1'b1, 10);
        host_board_i.set_select(1'b1);
        wait_lvl("select_off", S_RSP, 1'b0, 10);
        host_board_i.set_lp(1'b1);
        wait_lvl("lp_pin_on", S_LP, 1'b1, 10);
        host_board_i.set_lp(1'b0);
        wait_lvl("lp_pin_off", S_LP, 1'b0, 10);
        bus_xfer(1'b1, ADDR_CONTROL, 32'h1, rd);
        wait_lvl("pdown_on", S_LP, 1'b1, 5);
        rd_chk("control", ADDR_CONTROL, 32'h1);
        bus_xfer(1'b1, ADDR_CONTROL, 32'h0, rd);
        wait_lvl("pdown_off", S_LP, 1'b0, 5);
        test_done("pins");

        // corner sources first, then random ones
        for (int k = 0; k < 14; k++) begin
            idx = (k < 6) ? corner[k] : $urandom_range(15, 0);
            fire(idx);
            wait_lvl("event_int", S_OE, 1'b1, 5);
            rd_chk("event_flag", ADDR_FLAGS, flag_bit(idx));
            wait_lvl("event_release", S_OE, 1'b0, 10);
        end
        test_done("events");

        idx = $urandom_range(15, 0);
        bus_xfer(1'b1, ADDR_MASK, flag_bit(idx), rd);
        rd_chk("mask", ADDR_MASK, flag_bit(idx));
        fire(idx);
        repeat (6) @(negedge mclk);
        check("masked_int", {31'h0, interrupt_pin_n_oe}, 32'h0);
        bus_xfer(1'b1, ADDR_MASK, (32'h1 << FLAG_W) - 32'h1, rd);
        rd_chk("mask_all", ADDR_MASK, (32'h1 << FLAG_W) - 32'h1);
        check("all_masked_int", {31'h0, interrupt_pin_n_oe}, 32'h0);
        bus_xfer(1'b1, ADDR_MASK, 32'h0, rd);
        wait_lvl("unmask_int", S_OE, 1'b1, 5);
        rd_chk("masked_flag", ADDR_FLAGS, flag_bit(idx));
        wait_lvl("unmask_release", S_OE, 1'b0, 10);
        test_done("mask");

        fire(corner[1]);
        host_board_i.pulse_reset(PULSE_N + 10);
        wait_lvl("hold_not_ready", S_NR, 1'b1, 2);
        wait_lvl("restart_ready", S_NR, 1'b0, INIT_N + 20);
        wait_lvl("restart_int", S_OE, 1'b1, 4);
        rd_chk("restart_flag", ADDR_FLAGS, flag_bit(FLAG_READY_BIT));
        wait_lvl("restart_release", S_OE, 1'b0, 10);
        test_done("reset_pin");

        report_and_stop();
    end
endmodule
